// file: src/cwu_top.sv
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps

// What this block does
// - generator runs from the system clock; the clock select bit only feeds the fast oscillator request
// - fast oscillator request stays on in sleep when enabled, input active, selected
// - both clocks on fast oscillator: cpu idles, generator keeps running in sleep
// - in shutdown, output A and B driven at their override level bits
// - polarity never applies to override levels
// - without auto-restart, shutdown holds until software clears the bit
// - software clear of shutdown only succeeds when all selected sources are low
// - after clear, overrides hold until next input rising edge, then resume
// - with auto-restart, hardware clears shutdown when all sources are low
module cwu_top #(
	parameter int DB_W = 8,
	parameter int NSRC = 4,
	parameter int NIN = 4
) (
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// waveform, shutdown and sleep inputs
	input wire logic [NIN-1:0] i_wave_src,
	input wire logic [NSRC-1:0] i_shdn_src,
	input wire logic i_sleep,
	// outputs
	output logic o_out_a,
	output logic o_out_a_oe,
	output logic o_out_b,
	output logic o_out_b_oe,
	output logic o_fast_osc_req,
	output logic o_irq
);

	// =============================================================
	// registers
	cwu_pkg::cwu_bus_req_t req;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] insel_q, insel_d;
	logic [7:0] shdn_q, shdn_d;
	logic [DB_W-1:0] dbr_q, dbr_d, dbf_q, dbf_d;
	logic [cwu_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
	logic [7:0] rdata_q, rdata_d;
	cwu_pkg::cwu_state_t st_q, st_d;
	logic in_q, in_d;
	logic out_a_q, out_a_d, out_b_q, out_b_d;

	logic wave_in, any_shdn, rise, en, active, wr_shdn, sw_clear;
	logic db_a, db_b;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	function automatic logic hit_wr(input cwu_pkg::cwu_bus_req_t r, input logic [2:0] a);
		hit_wr = r.wr && (r.addr == a);
	endfunction : hit_wr

	assign wave_in = i_wave_src[insel_q[$clog2(NIN)-1:0]];
	assign any_shdn = |(i_shdn_src & shdn_q[cwu_pkg::SHDN_SRC_LSB +: NSRC]);
	assign rise = wave_in && !in_q;
	assign en = ctrl_q[cwu_pkg::CTRL_EN_BIT];
	assign active = shdn_q[cwu_pkg::SHDN_ACTIVE_BIT];
	assign wr_shdn = hit_wr(req, cwu_pkg::ADDR_SHDN);
	assign sw_clear = wr_shdn && !i_wdata[cwu_pkg::SHDN_ACTIVE_BIT];

	// =============================================================
	// register file and shutdown bit
	always_comb
	begin
		ctrl_d = hit_wr(req, cwu_pkg::ADDR_CTRL) ? i_wdata : ctrl_q;
		insel_d = hit_wr(req, cwu_pkg::ADDR_INSEL) ? i_wdata : insel_q;
		dbr_d = hit_wr(req, cwu_pkg::ADDR_DBR) ? i_wdata[DB_W-1:0] : dbr_q;
		dbf_d = hit_wr(req, cwu_pkg::ADDR_DBF) ? i_wdata[DB_W-1:0] : dbf_q;
		imask_d = hit_wr(req, cwu_pkg::ADDR_IRQ_MASK) ? i_wdata[cwu_pkg::IRQ_W-1:0] : imask_q;
		shdn_d = wr_shdn ? i_wdata : shdn_q;
		// software may set the bit unless the same write sets auto-restart with sources low; a clear only sticks when sources are low
		if (sw_clear && any_shdn)
			shdn_d[cwu_pkg::SHDN_ACTIVE_BIT] = 1'b1;
		else if (!wr_shdn && active && !any_shdn && shdn_q[cwu_pkg::SHDN_ARSEN_BIT])
			shdn_d[cwu_pkg::SHDN_ACTIVE_BIT] = 1'b0;
		if (wr_shdn && i_wdata[cwu_pkg::SHDN_ARSEN_BIT] && !any_shdn)
			shdn_d[cwu_pkg::SHDN_ACTIVE_BIT] = 1'b0;
		if (any_shdn)
			shdn_d[cwu_pkg::SHDN_ACTIVE_BIT] = 1'b1;
		ist_d = ist_q;
		if (hit_wr(req, cwu_pkg::ADDR_IRQ_STAT))
			ist_d = ist_q & ~i_wdata[cwu_pkg::IRQ_W-1:0];
		// set wins over clear
		if (!active && shdn_d[cwu_pkg::SHDN_ACTIVE_BIT])
			ist_d[cwu_pkg::IRQ_SHDN_BIT] = 1'b1;
		if (st_q != cwu_pkg::CWU_ST_RUN && st_d == cwu_pkg::CWU_ST_RUN)
			ist_d[cwu_pkg::IRQ_RESUME_BIT] = 1'b1;
		unique case (i_addr)
			cwu_pkg::ADDR_CTRL: rdata_d = ctrl_q;
			cwu_pkg::ADDR_INSEL: rdata_d = insel_q;
			cwu_pkg::ADDR_SHDN: rdata_d = shdn_q;
			cwu_pkg::ADDR_DBR: rdata_d = 8'(dbr_q);
			cwu_pkg::ADDR_DBF: rdata_d = 8'(dbf_q);
			cwu_pkg::ADDR_IRQ_STAT: rdata_d = 8'(ist_q);
			cwu_pkg::ADDR_IRQ_MASK: rdata_d = 8'(imask_q);
			cwu_pkg::ADDR_STATUS: rdata_d = {5'h00, wave_in, st_q};
		endcase
		if (!i_rd)
			rdata_d = cwu_pkg::RST_BYTE;
	end

	// =============================================================
	// restart sequencing
	always_comb
	begin
		st_d = st_q;
		in_d = wave_in;
		unique case (st_q)
			cwu_pkg::CWU_ST_OFF:
				if (en)
					st_d = active ? cwu_pkg::CWU_ST_SHUT : cwu_pkg::CWU_ST_WAIT_EDGE;
			cwu_pkg::CWU_ST_SHUT:
				// an edge in the cycle right after the clear is already the first one
				if (!active && rise)
					st_d = cwu_pkg::CWU_ST_RUN;
				else if (!active)
					st_d = cwu_pkg::CWU_ST_WAIT_EDGE;
			cwu_pkg::CWU_ST_WAIT_EDGE:
				if (active)
					st_d = cwu_pkg::CWU_ST_SHUT;
				else if (rise)
					st_d = cwu_pkg::CWU_ST_RUN;
			cwu_pkg::CWU_ST_RUN:
				if (active)
					st_d = cwu_pkg::CWU_ST_SHUT;
		endcase
		if (!en)
			st_d = cwu_pkg::CWU_ST_OFF;
	end

	// =============================================================
	// dead-band on each complementary edge
	cwu_deadband #(.W(DB_W)) u_db_a (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_in(wave_in),
		.i_delay(dbr_q),
		.o_out(db_a)
	);

	cwu_deadband #(.W(DB_W)) u_db_b (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_in(!wave_in),
		.i_delay(dbf_q),
		.o_out(db_b)
	);

	// =============================================================
	// output drive
	always_comb
	begin
		out_a_d = 1'b0;
		out_b_d = 1'b0;
		if (st_d == cwu_pkg::CWU_ST_RUN)
		begin
			out_a_d = db_a ^ ctrl_q[cwu_pkg::CTRL_POLA_BIT];
			out_b_d = db_b ^ ctrl_q[cwu_pkg::CTRL_POLB_BIT];
		end
		else if (st_d != cwu_pkg::CWU_ST_OFF)
		begin
			// override levels bypass polarity on purpose
			out_a_d = shdn_d[cwu_pkg::SHDN_LVLA_BIT];
			out_b_d = shdn_d[cwu_pkg::SHDN_LVLB_BIT];
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			ctrl_q <= cwu_pkg::RST_CTRL;
			insel_q <= cwu_pkg::RST_BYTE;
			shdn_q <= cwu_pkg::RST_SHDN;
			dbr_q <= '0;
			dbf_q <= '0;
			ist_q <= '0;
			imask_q <= '0;
			rdata_q <= cwu_pkg::RST_BYTE;
			st_q <= cwu_pkg::CWU_ST_OFF;
			in_q <= 1'b0;
			out_a_q <= 1'b0;
			out_b_q <= 1'b0;
		end
		else if (i_ce)
		begin
			ctrl_q <= ctrl_d;
			insel_q <= insel_d;
			shdn_q <= shdn_d;
			dbr_q <= dbr_d;
			dbf_q <= dbf_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			rdata_q <= rdata_d;
			st_q <= st_d;
			in_q <= in_d;
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
		end
	end

	// sleep does not gate this block; not even the oscillator request depends on it
	assign o_fast_osc_req = en && wave_in
		&& ctrl_q[cwu_pkg::CTRL_CLKSEL_BIT];
	assign o_out_a = out_a_q;
	assign o_out_b = out_b_q;
	assign o_out_a_oe = en && ctrl_q[cwu_pkg::CTRL_OEA_BIT];
	assign o_out_b_oe = en && ctrl_q[cwu_pkg::CTRL_OEB_BIT];
	assign o_rdata = rdata_q;
	assign o_irq = |(ist_q & imask_q);

	// =============================================================
	// assertions
	property p_override_a;
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_ce && (st_q == cwu_pkg::CWU_ST_SHUT)) |-> (o_out_a == shdn_q[cwu_pkg::SHDN_LVLA_BIT]);
	endproperty
	a_override_a: assert property (p_override_a) else $error("output a not at override");

	// either polarity bit set: both levels still pass unchanged, before and after the clear
	property p_override_b_nopol;
		@(posedge i_sys_clk) disable iff (i_srst)
		((st_q == cwu_pkg::CWU_ST_SHUT || st_q == cwu_pkg::CWU_ST_WAIT_EDGE)
			&& (ctrl_q[cwu_pkg::CTRL_POLA_BIT] || ctrl_q[cwu_pkg::CTRL_POLB_BIT]))
		|-> (o_out_b == shdn_q[cwu_pkg::SHDN_LVLB_BIT]
			&& o_out_a == shdn_q[cwu_pkg::SHDN_LVLA_BIT]);
	endproperty
	a_override_b_nopol: assert property (p_override_b_nopol)
		else $error("override inverted");

	property p_clear_blocked;
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_ce && sw_clear && any_shdn) |=> active;
	endproperty
	a_clear_blocked: assert property (p_clear_blocked)
		else $error("clear taken with source high");

	property p_clear_taken;
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_ce && sw_clear && !any_shdn) |=> !active;
	endproperty
	a_clear_taken: assert property (p_clear_taken) else $error("clear refused");

	property p_set_on_src;
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_ce && any_shdn) |=> active;
	endproperty
	a_set_on_src: assert property (p_set_on_src) else $error("shutdown bit not set");

	property p_autorestart;
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_ce && !req.wr && active && !any_shdn && shdn_q[cwu_pkg::SHDN_ARSEN_BIT]) |=> !active;
	endproperty
	a_autorestart: assert property (p_autorestart) else $error("auto restart missed");

	property p_hold_no_ar;
		@(posedge i_sys_clk) disable iff (i_srst)
		(active && !shdn_q[cwu_pkg::SHDN_ARSEN_BIT] && !wr_shdn) |=> active;
	endproperty
	a_hold_no_ar: assert property (p_hold_no_ar)
		else $error("shutdown cleared by itself");

	property p_resume_edge;
		@(posedge i_sys_clk) disable iff (i_srst)
		(st_q != cwu_pkg::CWU_ST_RUN) ##1 (st_q == cwu_pkg::CWU_ST_RUN) |-> $past(rise);
	endproperty
	a_resume_edge: assert property (p_resume_edge) else $error("resume without edge");

	property p_osc;
		@(posedge i_sys_clk) disable iff (i_srst)
		(en && wave_in && ctrl_q[cwu_pkg::CTRL_CLKSEL_BIT] && i_sleep) |-> o_fast_osc_req;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator dropped in sleep");

	// sleep is only watched: the sequencer must step on regardless
	property p_sleep_runs;
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_ce && i_sleep && en && !active && st_q == cwu_pkg::CWU_ST_WAIT_EDGE && rise)
		|=> (st_q == cwu_pkg::CWU_ST_RUN);
	endproperty
	a_sleep_runs: assert property (p_sleep_runs)
		else $error("generator stalled in sleep");

	c_shut: cover property (@(posedge i_sys_clk) st_q == cwu_pkg::CWU_ST_SHUT);
	c_resume: cover property (@(posedge i_sys_clk)
		st_q == cwu_pkg::CWU_ST_WAIT_EDGE ##1 st_q == cwu_pkg::CWU_ST_RUN);
	c_irq: cover property (@(posedge i_sys_clk) o_irq);
	c_auto_clear: cover property (@(posedge i_sys_clk)
		active && shdn_q[cwu_pkg::SHDN_ARSEN_BIT] ##1 !active);
	c_sleep_run: cover property (@(posedge i_sys_clk)
		i_sleep && st_q == cwu_pkg::CWU_ST_RUN);

endmodule : cwu_top

// file: src/cwu_pkg.sv
package cwu_pkg;

	// =============================================================
	// register map (word index = byte address / 4 not used: plain port)
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_INSEL = 3'h1;
	localparam logic [2:0] ADDR_SHDN = 3'h2;
	localparam logic [2:0] ADDR_DBR = 3'h3;
	localparam logic [2:0] ADDR_DBF = 3'h4;
	localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;
	localparam logic [2:0] ADDR_STATUS = 3'h7;

	// =============================================================
	// control register fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OEB_BIT = 6;
	localparam int CTRL_OEA_BIT = 5;
	localparam int CTRL_POLB_BIT = 4;
	localparam int CTRL_POLA_BIT = 3;
	localparam int CTRL_CLKSEL_BIT = 0;

	// shutdown control register fields
	localparam int SHDN_ACTIVE_BIT = 7;
	localparam int SHDN_ARSEN_BIT = 6;
	localparam int SHDN_LVLB_BIT = 5;
	localparam int SHDN_LVLA_BIT = 4;
	localparam int SHDN_SRC_LSB = 0;
	localparam int SHDN_SRC_W = 4;

	// interrupt status fields
	localparam int IRQ_SHDN_BIT = 0;
	localparam int IRQ_RESUME_BIT = 1;
	localparam int IRQ_W = 2;

	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_SHDN = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// =============================================================
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cwu_bus_req_t;

	typedef enum logic [1:0] {
		CWU_ST_OFF = 2'b00,
		CWU_ST_SHUT = 2'b01,
		CWU_ST_WAIT_EDGE = 2'b10,
		CWU_ST_RUN = 2'b11
	} cwu_state_t;

endpackage : cwu_pkg

// file: src/cwu_deadband.sv
`timescale 1ns/100ps

// =============================================================
// dead-band delay of one rising transition
module cwu_deadband #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// data
	input wire logic i_in,
	input wire logic [W-1:0] i_delay,
	output logic o_out
);

	logic [W-1:0] cnt_q, cnt_d;
	logic out_q, out_d;

	always_comb
	begin
		cnt_d = cnt_q;
		out_d = out_q;
		if (!i_in)
		begin
			out_d = 1'b0;
			cnt_d = '0;
		end
		else if (!out_q)
		begin
			if (cnt_q >= i_delay)
				out_d = 1'b1;
			else
				cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end
		else if (i_ce)
		begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign o_out = out_q;

endmodule : cwu_deadband

// file: verification/cwu_power_stage.sv
`timescale 1ns/100ps

// =============================================================
// power stage: reports a commanded trip as a fault level
module cwu_power_stage (
	// clock
	input wire logic i_sys_clk,
	// gate drive enables
	input wire logic i_gate_a_oe,
	input wire logic i_gate_b_oe,
	// fault control
	input wire logic i_trip,
	input wire logic i_slow,
	output logic o_fault
);
	logic [3:0] trip_q = 4'h0;
	// an undriven stage cannot trip, so nothing reaches the fault line before enable
	always @(posedge i_sys_clk)
		trip_q <= {trip_q[2:0], i_trip & i_gate_a_oe & i_gate_b_oe};
	// slow answer lags the trip by four cycles
	assign o_fault = i_slow ? trip_q[3] : trip_q[0];
endmodule : cwu_power_stage

// file: verification/cwu_tb_top.sv
`timescale 1ns/100ps

module cwu_tb_top;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] i_wave_src = 4'h0;
	logic i_sleep = 1'b0;
	logic ce = 1'b1;
	logic trip = 1'b0;
	logic slow = 1'b0;
	logic src1 = 1'b0;
	logic fault;
	logic [7:0] o_rdata;
	logic [7:0] rd_q;
	logic o_out_a, o_out_a_oe, o_out_b, o_out_b_oe, o_fast_osc_req, o_irq;
	int n_errors = 0;
	int n_compared = 0;

	always #10 i_sys_clk = ~i_sys_clk;

	cwu_top DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(ce), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_wave_src(i_wave_src), .i_shdn_src({2'h0, src1, fault}), .i_sleep(i_sleep),
		.o_out_a(o_out_a), .o_out_a_oe(o_out_a_oe), .o_out_b(o_out_b),
		.o_out_b_oe(o_out_b_oe), .o_fast_osc_req(o_fast_osc_req), .o_irq(o_irq));

	cwu_power_stage STAGE (.i_sys_clk(i_sys_clk), .i_gate_a_oe(o_out_a_oe),
		.i_gate_b_oe(o_out_b_oe), .i_trip(trip), .i_slow(slow), .o_fault(fault));

	// =============================================================
	// bus and compare helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 rd_q = o_rdata;
	endtask : rd

	// polls the state field with a bounded number of reads
	task automatic wait_state(input logic [1:0] s);
		int k = 0;
		rd(cwu_pkg::ADDR_STATUS);
		while (rd_q[1:0] !== s && k < 20)
		begin
			rd(cwu_pkg::ADDR_STATUS);
			k++;
		end
		chk({6'h0, rd_q[1:0]}, {6'h0, s});
		if (rd_q[1:0] !== s)
			tally_and_finish();
	endtask : wait_state

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// =============================================================
	// scenarios
	task automatic t_reset();
		rd(cwu_pkg::ADDR_CTRL);
		chk(rd_q, cwu_pkg::RST_CTRL);
		rd(cwu_pkg::ADDR_SHDN);
		chk(rd_q, cwu_pkg::RST_SHDN);
		chk({3'h0, o_out_a, o_out_a_oe, o_out_b, o_out_b_oe, o_irq}, 8'h00);
		$display("reset test done");
	endtask : t_reset

	task automatic t_bringup();
		wr(cwu_pkg::ADDR_DBR, 8'h02);
		wr(cwu_pkg::ADDR_DBF, 8'h02);
		// shut down, override a high and b low, source 0 only
		wr(cwu_pkg::ADDR_SHDN, 8'h91);
		wr(cwu_pkg::ADDR_INSEL, 8'h00);
		wr(cwu_pkg::ADDR_CTRL, 8'h68);
		wr(cwu_pkg::ADDR_CTRL, 8'he8);
		wait_state(2'h1);
		// a is inverted, yet the pin shows the override bit as written
		chk({6'h0, o_out_a, o_out_b}, 8'h02);
		chk({6'h0, o_out_a_oe, o_out_b_oe}, 8'h03);
		$display("bring-up test done");
	endtask : t_bringup

	task automatic t_soft_restart();
		trip <= 1'b1;
		wr(cwu_pkg::ADDR_SHDN, 8'h11);
		rd(cwu_pkg::ADDR_SHDN);
		chk(rd_q, 8'h91);
		trip <= 1'b0;
		rd(cwu_pkg::ADDR_SHDN);
		chk(rd_q, 8'h91);
		// a high source that is not selected must not hold shutdown
		@(posedge i_sys_clk);
		src1 <= 1'b1;
		wr(cwu_pkg::ADDR_SHDN, 8'h11);
		wait_state(2'h2);
		chk({6'h0, o_out_a, o_out_b}, 8'h02);
		@(posedge i_sys_clk);
		i_wave_src <= 4'h1;
		wait_state(2'h3);
		repeat (4) @(posedge i_sys_clk);
		#1 chk({6'h0, o_out_a, o_out_b}, 8'h00);
		@(posedge i_sys_clk);
		src1 <= 1'b0;
		$display("software restart test done");
	endtask : t_soft_restart

	task automatic t_auto_restart();
		// flags left from earlier tests would raise the line before any shutdown
		wr(cwu_pkg::ADDR_IRQ_STAT, 8'h03);
		wr(cwu_pkg::ADDR_IRQ_MASK, 8'h01);
		#1 chk({7'h0, o_irq}, 8'h00);
		slow <= 1'b1;
		trip <= 1'b1;
		wait_state(2'h1);
		chk({6'h0, o_out_a, o_out_b}, 8'h02);
		chk({7'h0, o_irq}, 8'h01);
		wr(cwu_pkg::ADDR_IRQ_MASK, 8'h00);
		#1 chk({7'h0, o_irq}, 8'h00);
		wr(cwu_pkg::ADDR_SHDN, 8'hd1);
		rd(cwu_pkg::ADDR_SHDN);
		chk(rd_q, 8'hd1);
		trip <= 1'b0;
		wait_state(2'h2);
		wr(cwu_pkg::ADDR_IRQ_STAT, 8'h01);
		rd(cwu_pkg::ADDR_IRQ_STAT);
		chk(rd_q & 8'h01, 8'h00);
		$display("auto restart test done");
	endtask : t_auto_restart

	task automatic t_sleep();
		@(posedge i_sys_clk);
		i_wave_src <= 4'h0;
		wr(cwu_pkg::ADDR_CTRL, 8'he9);
		i_wave_src <= 4'h1;
		i_sleep <= 1'b1;
		wait_state(2'h3);
		chk({7'h0, o_fast_osc_req}, 8'h01);
		repeat (4) @(posedge i_sys_clk);
		#1 chk({6'h0, o_out_a, o_out_b}, 8'h00);
		@(posedge i_sys_clk);
		i_wave_src <= 4'h0;
		repeat (2) @(posedge i_sys_clk);
		#1 chk({7'h0, o_fast_osc_req}, 8'h00);
		$display("sleep test done");
	endtask : t_sleep

	// a write while the clock enable is low must not land
	task automatic t_freeze();
		@(posedge i_sys_clk);
		ce <= 1'b0;
		wr(cwu_pkg::ADDR_DBR, 8'h05);
		ce <= 1'b1;
		rd(cwu_pkg::ADDR_DBR);
		chk(rd_q, 8'h02);
		$display("clock enable test done");
	endtask : t_freeze

	initial
	begin
		repeat (20) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		t_reset();
		t_bringup();
		t_soft_restart();
		t_auto_restart();
		t_sleep();
		t_freeze();
		tally_and_finish();
	end
endmodule : cwu_tb_top
